// *** core/usb_phy_ctrl_params.svh ***
// Offsets, field positions, reset values and counts of the transceiver control registers
`ifndef USB_PHY_CTRL_PARAMS_SVH
`define USB_PHY_CTRL_PARAMS_SVH
// Behaviour
// - The flags mask at 0x38 is a 32-bit read-write word that resets to zero and reads back what was written.
// - The power word at 0x3C holds read-write data in bits 7:0 and a valid bit at 8, zero at reset, upper bits zero.
// - Bit 18 of the control register at one turns off the pulldowns on both port pins; zero keeps them on.
// - Bit 13 is set by hardware when an auto-resume was woken by SE0 and is cleared by writing zero.
// - Bit 12 is set by hardware when an auto-resume was woken by a K state and is cleared by writing zero.
// - A linestate change passes only after it has held for two to the power of bits 11:8 clock cycles.
// - Bit 7 at one lets the suspend controller resume by itself; at zero software polls the filtered linestate.
// - Bits 6:4 drive the three transceiver configuration pins directly and bits 3:0 read as zero.
// - The control register sits at 0x40 and bits 31:19 and 17:14 are read-only zero.

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_OTG_FLAG_MASK   8'h38
`define OFF_POWER_SIGNAL    8'h3C
`define OFF_XCVR_CTRL       8'h40
`define OFF_IRQ_STATUS      8'h44
`define OFF_IRQ_CLEAR       8'h48
`define OFF_IRQ_ENABLE      8'h4C
`define OFF_LINE_STATUS     8'h50

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PWR_VALID_BIT       8
`define CTRL_PD_DIS_BIT     18
`define CTRL_WAKE_SE0_BIT   13
`define CTRL_WAKE_K_BIT     12
`define CTRL_FILT_HI        11
`define CTRL_FILT_LO        8
`define CTRL_AUTO_BIT       7
`define CTRL_CFG_HI         6
`define CTRL_CFG_LO         4
`define LSTAT_ASLEEP_BIT    2

// ----------------------------------------------------------------
// Events, reset values, counts
// ----------------------------------------------------------------
`define EV_W                3
`define EV_WAKE_K           0
`define EV_WAKE_SE0         1
`define EV_LINE_CHG         2
`define RST_WORD            32'h0000_0000
`define FILT_RUN_W          16
`endif

// *** core/usb_phy_ctrl_pkg.sv ***
// Types shared by the transceiver control register block
`include "usb_phy_ctrl_params.svh"
package usb_phy_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_AWAKE  = 2'b01,
    ST_ASLEEP = 2'b10
  } susp_state_t;

  typedef enum logic [1:0] {
    LS_SE0 = 2'b00,
    LS_J   = 2'b01,
    LS_K   = 2'b10,
    LS_SE1 = 2'b11
  } line_state_t;

  typedef struct packed {
    logic        pd_dis;
    logic        wake_se0;
    logic        wake_k;
    logic [3:0]  filt_log2;
    logic        auto_resume;
    logic [2:0]  cfg;
  } xcvr_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } power_word_t;

  typedef struct packed {
    logic [1:0]             last;
    logic [`FILT_RUN_W-1:0] run;
    logic [1:0]             filt;
    logic                   chg;
  } filt_state_t;

  typedef struct packed {
    logic              ap_valid;
    logic              ap_write;
    logic [7:2]        ap_addr;
    logic [31:0]       rdata;
    logic [31:0]       otg_mask;
    power_word_t       pwr;
    xcvr_ctrl_t        ctrl;
    logic [`EV_W-1:0]  irq_stat;
    logic [`EV_W-1:0]  irq_en;
    susp_state_t       susp;
    logic              wake;
  } regs_state_t;
endpackage : usb_phy_ctrl_pkg

// *** core/linestate_filter.sv ***
// Persistence filter for the transceiver linestate
`timescale 1ns/1ps
`include "usb_phy_ctrl_params.svh"
module linestate_filter
  import usb_phy_ctrl_pkg::*;
(
  input  wire logic       core_clk,   // Core clock
  input  wire logic       rst_n,      // Async reset, active low
  input  wire logic [1:0] line_raw,   // Linestate from transceiver
  input  wire logic [3:0] log2_len,   // Log2 of hold time in cycles
  output logic      [1:0] line_filt,  // Filtered linestate
  output logic            line_chg    // Pulse on filtered change
);
  filt_state_t cur_ff;
  filt_state_t nxt_st;
  logic [`FILT_RUN_W:0] need;

  // ----------------------------------------------------------------
  // Run-length counter
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st      = cur_ff;
    nxt_st.chg  = 1'b0;
    nxt_st.last = line_raw;
    need        = (`FILT_RUN_W+1)'(1) << log2_len;
    // Saturates so a long idle line cannot wrap
    if (line_raw != cur_ff.last) begin
      nxt_st.run = `FILT_RUN_W'(1);
    end else if (cur_ff.run != '1) begin
      nxt_st.run = cur_ff.run + 1'b1;
    end
    if (cur_ff.last != cur_ff.filt && {1'b0, cur_ff.run} >= need) begin
      nxt_st.filt = cur_ff.last;
      nxt_st.chg  = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign line_filt = cur_ff.filt;
  assign line_chg  = cur_ff.chg;

  property p_hold_time;
    @(posedge core_clk) disable iff (!rst_n)
    $changed(cur_ff.filt) |-> {1'b0, $past(cur_ff.run)} >= ((`FILT_RUN_W+1)'(1) << $past(log2_len));
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("Linestate passed before hold time");
endmodule : linestate_filter

// *** core/usb_phy_control_registers.sv ***
// Transceiver control registers behind an AHB-Lite slave
`timescale 1ns/1ps
`include "usb_phy_ctrl_params.svh"
module usb_phy_control_registers
  import usb_phy_ctrl_pkg::*;
(
  input  wire logic        core_clk,                // Core clock, 100 MHz
  input  wire logic        rst_n,                   // Async reset, active low
  input  wire logic        hsel,                    // Slave select
  input  wire logic [31:0] haddr,                   // Byte address
  input  wire logic [1:0]  htrans,                  // Transfer type
  input  wire logic        hwrite,                  // Write when high
  input  wire logic [2:0]  hsize,                   // Word only
  input  wire logic [31:0] hwdata,                  // Write data
  input  wire logic        hready,                  // Bus ready
  output logic             hreadyout,               // Slave ready
  output logic             hresp,                   // Always OKAY
  output logic      [31:0] hrdata,                  // Read data
  input  wire logic [1:0]  line_state,              // Raw linestate
  input  wire logic        link_suspend,            // Link asks suspend
  output logic             auto_wake,               // Resume pulse to link
  output logic      [31:0] otg_flag_mask,           // Flags mask word
  output logic      [7:0]  power_signal_data,       // Power data
  output logic             power_signal_valid,      // Power data valid
  output logic      [2:0]  transceiver_config_pins, // Config pins
  output logic             usb_port_pin_a_pd_en,    // Pulldown on pin a
  output logic             usb_port_pin_b_pd_en,    // Pulldown on pin b
  output logic             irq                      // Level interrupt
);
  regs_state_t       cur_ff;
  regs_state_t       nxt_st;
  logic [1:0]        line_filt;
  logic              line_chg;
  logic              addr_acc;
  logic [`EV_W-1:0]  ev;
  logic [7:0]        dp_addr;

  // ----------------------------------------------------------------
  // Linestate filter
  // ----------------------------------------------------------------
  linestate_filter u_filt (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .line_raw  (line_state),
    .log2_len  (cur_ff.ctrl.filt_log2),
    .line_filt (line_filt),
    .line_chg  (line_chg)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_mux(
    input regs_state_t s,
    input logic [7:0]  a,
    input logic [1:0]  lf
  );
    logic [31:0] r;
    r = `RST_WORD;
    case (a)
      `OFF_OTG_FLAG_MASK: r = s.otg_mask;
      `OFF_POWER_SIGNAL: r[`PWR_VALID_BIT:0] = s.pwr;
      `OFF_XCVR_CTRL: begin
        r[`CTRL_PD_DIS_BIT]                = s.ctrl.pd_dis;
        r[`CTRL_WAKE_SE0_BIT]              = s.ctrl.wake_se0;
        r[`CTRL_WAKE_K_BIT]                = s.ctrl.wake_k;
        r[`CTRL_FILT_HI:`CTRL_FILT_LO]     = s.ctrl.filt_log2;
        r[`CTRL_AUTO_BIT]                  = s.ctrl.auto_resume;
        r[`CTRL_CFG_HI:`CTRL_CFG_LO]       = s.ctrl.cfg;
      end
      `OFF_IRQ_STATUS: r[`EV_W-1:0] = s.irq_stat;
      `OFF_IRQ_ENABLE: r[`EV_W-1:0] = s.irq_en;
      `OFF_LINE_STATUS: begin
        r[1:0]               = lf;
        r[`LSTAT_ASLEEP_BIT] = (s.susp == ST_ASLEEP);
      end
      default: r = `RST_WORD;
    endcase
    return r;
  endfunction : read_mux

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign addr_acc = hsel && htrans[1] && hready;
  assign dp_addr  = {cur_ff.ap_addr, 2'b00};

  always_comb begin
    nxt_st      = cur_ff;
    nxt_st.wake = 1'b0;
    ev          = '0;

    // Data phase write; hsize is ignored, only words are used
    if (cur_ff.ap_valid && cur_ff.ap_write) begin
      case (dp_addr)
        `OFF_OTG_FLAG_MASK: nxt_st.otg_mask = hwdata;
        `OFF_POWER_SIGNAL: nxt_st.pwr = hwdata[`PWR_VALID_BIT:0];
        `OFF_XCVR_CTRL: begin
          nxt_st.ctrl.pd_dis      = hwdata[`CTRL_PD_DIS_BIT];
          nxt_st.ctrl.wake_se0    = cur_ff.ctrl.wake_se0 & hwdata[`CTRL_WAKE_SE0_BIT];
          nxt_st.ctrl.wake_k      = cur_ff.ctrl.wake_k & hwdata[`CTRL_WAKE_K_BIT];
          nxt_st.ctrl.filt_log2   = hwdata[`CTRL_FILT_HI:`CTRL_FILT_LO];
          nxt_st.ctrl.auto_resume = hwdata[`CTRL_AUTO_BIT];
          nxt_st.ctrl.cfg         = hwdata[`CTRL_CFG_HI:`CTRL_CFG_LO];
        end
        `OFF_IRQ_CLEAR: nxt_st.irq_stat = cur_ff.irq_stat & ~hwdata[`EV_W-1:0];
        `OFF_IRQ_ENABLE: nxt_st.irq_en = hwdata[`EV_W-1:0];
        default: ;
      endcase
    end

    unique case (cur_ff.susp)
      ST_AWAKE: begin
        // Only a J line may enter, else a held K would wake at once
        if (cur_ff.ctrl.auto_resume && link_suspend && line_filt == LS_J) begin
          nxt_st.susp = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (!cur_ff.ctrl.auto_resume) begin
          nxt_st.susp = ST_AWAKE;
        end else if (line_filt == LS_K) begin
          ev[`EV_WAKE_K] = 1'b1;
          nxt_st.susp    = ST_AWAKE;
          nxt_st.wake    = 1'b1;
        end else if (line_filt == LS_SE0) begin
          ev[`EV_WAKE_SE0] = 1'b1;
          nxt_st.susp      = ST_AWAKE;
          nxt_st.wake      = 1'b1;
        end
      end
    endcase
    ev[`EV_LINE_CHG] = line_chg;

    nxt_st.ctrl.wake_k   = nxt_st.ctrl.wake_k | ev[`EV_WAKE_K];
    nxt_st.ctrl.wake_se0 = nxt_st.ctrl.wake_se0 | ev[`EV_WAKE_SE0];
    nxt_st.irq_stat      = nxt_st.irq_stat | ev;

    // Address phase; read sees this cycle's write
    nxt_st.ap_valid = addr_acc;
    if (addr_acc) begin
      nxt_st.ap_write = hwrite;
      nxt_st.ap_addr  = haddr[7:2];
      if (!hwrite) begin
        nxt_st.rdata = read_mux(nxt_st, {haddr[7:2], 2'b00}, line_filt);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff      <= '0;
      cur_ff.susp <= ST_AWAKE;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign hrdata                  = cur_ff.rdata;
  assign auto_wake               = cur_ff.wake;
  assign otg_flag_mask           = cur_ff.otg_mask;
  assign power_signal_data       = cur_ff.pwr.data;
  assign power_signal_valid      = cur_ff.pwr.valid;
  assign transceiver_config_pins = cur_ff.ctrl.cfg;
  assign usb_port_pin_a_pd_en    = !cur_ff.ctrl.pd_dis;
  assign usb_port_pin_b_pd_en    = !cur_ff.ctrl.pd_dis;
  assign irq                     = |(cur_ff.irq_stat & cur_ff.irq_en);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mask_store;
    @(posedge core_clk) disable iff (!rst_n)
    cur_ff.ap_valid && cur_ff.ap_write && dp_addr == `OFF_OTG_FLAG_MASK
      |=> otg_flag_mask == $past(hwdata);
  endproperty
  a_mask_store: assert property (p_mask_store) else $error("Mask not stored");

  property p_power_store;
    @(posedge core_clk) disable iff (!rst_n)
    cur_ff.ap_valid && cur_ff.ap_write && dp_addr == `OFF_POWER_SIGNAL
      |=> power_signal_valid == $past(hwdata[`PWR_VALID_BIT]) && power_signal_data == $past(hwdata[7:0]);
  endproperty
  a_power_store: assert property (p_power_store) else $error("Power word not stored");

  property p_pulldown;
    @(posedge core_clk) disable iff (!rst_n)
    cur_ff.ap_valid && cur_ff.ap_write && dp_addr == `OFF_XCVR_CTRL
      |=> usb_port_pin_a_pd_en == !$past(hwdata[`CTRL_PD_DIS_BIT]) && usb_port_pin_b_pd_en == usb_port_pin_a_pd_en;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("Pulldown not following control");

  property p_wake_se0;
    @(posedge core_clk) disable iff (!rst_n)
    cur_ff.susp == ST_ASLEEP && cur_ff.ctrl.auto_resume && line_filt == LS_SE0
      |=> cur_ff.ctrl.wake_se0 && auto_wake ##1 !auto_wake;
  endproperty
  a_wake_se0: assert property (p_wake_se0) else $error("SE0 wake not flagged");

  property p_wake_k;
    @(posedge core_clk) disable iff (!rst_n)
    cur_ff.susp == ST_ASLEEP && cur_ff.ctrl.auto_resume && line_filt == LS_K
      |=> cur_ff.ctrl.wake_k && !cur_ff.ctrl.wake_se0 || $past(cur_ff.ctrl.wake_se0);
  endproperty
  a_wake_k: assert property (p_wake_k) else $error("K wake not flagged");

  property p_auto_off;
    @(posedge core_clk) disable iff (!rst_n)
    !cur_ff.ctrl.auto_resume |=> cur_ff.susp == ST_AWAKE && !auto_wake;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("Resumed without auto mode");

  property p_cfg_pins;
    @(posedge core_clk) disable iff (!rst_n)
    cur_ff.ap_valid && cur_ff.ap_write && dp_addr == `OFF_XCVR_CTRL
      |=> transceiver_config_pins == $past(hwdata[`CTRL_CFG_HI:`CTRL_CFG_LO]);
  endproperty
  a_cfg_pins: assert property (p_cfg_pins) else $error("Config pins not following control");

  property p_reserved;
    @(posedge core_clk) disable iff (!rst_n)
    addr_acc && !hwrite && haddr[7:0] == `OFF_XCVR_CTRL
      |=> hrdata[31:19] == 13'h0 && hrdata[17:14] == 4'h0 && hrdata[3:0] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved control bits not zero");

  property p_set_wins;
    @(posedge core_clk) disable iff (!rst_n)
    cur_ff.ap_valid && cur_ff.ap_write && dp_addr == `OFF_XCVR_CTRL && !hwdata[`CTRL_WAKE_K_BIT]
      && cur_ff.susp == ST_ASLEEP && cur_ff.ctrl.auto_resume && line_filt == LS_K
      |=> cur_ff.ctrl.wake_k;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Wake flag lost to clear");
endmodule : usb_phy_control_registers

// *** dv/usb_xcvr_model.sv ***
// Behavioural transceiver and link partner of the register block
`timescale 1ns/1ps
module usb_xcvr_model
  import usb_phy_ctrl_pkg::*;
(
  input  wire logic       core_clk,     // Core clock
  input  wire logic       auto_wake,    // Resume pulse from block
  output logic      [1:0] line_state,   // Linestate seen by block
  output logic            link_suspend  // Link asks for suspend
);
  initial begin
    line_state = LS_J;
    link_suspend = 1'b0;
  end

  // ----------------------------------------------------------------
  // Link reaction
  // ----------------------------------------------------------------
  // Link leaves suspend
  always @(posedge core_clk) begin
    if (auto_wake === 1'b1) begin
      link_suspend <= 1'b0;
    end
  end

  // Host drives a new bus level just after an edge
  task put(input logic [1:0] v);
    @(posedge core_clk);
    line_state <= v;
  endtask : put

  task set_susp(input logic v);
    @(posedge core_clk);
    link_suspend <= v;
  endtask : set_susp
endmodule : usb_xcvr_model

// *** dv/usb_phy_control_registers_tb.sv ***
// Self-checking bench of the transceiver control registers
`timescale 1ns/1ps
`include "usb_phy_ctrl_params.svh"
module usb_phy_control_registers_tb;
  import usb_phy_ctrl_pkg::*;
  logic        core_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic [1:0]  line_state;
  logic        link_suspend;
  logic        auto_wake;
  logic [31:0] otg_flag_mask;
  logic [7:0]  power_signal_data;
  logic        power_signal_valid;
  logic [2:0]  cfg_pins;
  logic        pd_a;
  logic        pd_b;
  logic        irq;
  int          num_errors;
  int          checks_done;
  int          cycles;

  usb_phy_control_registers u_usb_phy_control_registers (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(), .hrdata(hrdata), .line_state(line_state), .link_suspend(link_suspend),
    .auto_wake(auto_wake), .otg_flag_mask(otg_flag_mask), .power_signal_data(power_signal_data),
    .power_signal_valid(power_signal_valid), .transceiver_config_pins(cfg_pins),
    .usb_port_pin_a_pd_en(pd_a), .usb_port_pin_b_pd_en(pd_b), .irq(irq));

  usb_xcvr_model u_usb_xcvr_model (
    .core_clk(core_clk), .auto_wake(auto_wake), .line_state(line_state),
    .link_suspend(link_suspend));

  // ----------------------------------------------------------------
  // Clock, reset, timeout
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Whole run needs well under 3000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // Waits on hready each phase; the timeout ends a stuck slave
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask : ahb

  // Returns settled, so pins may be compared at once
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
    @(negedge core_clk);
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    chk_word(q & m, exp);
  endtask : rd

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] wv;
    int         n;
    int         cnt;
    core_clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`OFF_OTG_FLAG_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(`OFF_POWER_SIGNAL, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(`OFF_XCVR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    chk_bit(pd_a & pd_b, 1'b1);
    wr(`OFF_OTG_FLAG_MASK, 32'hA5A5_5A5A);
    rd(`OFF_OTG_FLAG_MASK, 32'hFFFF_FFFF, 32'hA5A5_5A5A);
    chk_word(otg_flag_mask, 32'hA5A5_5A5A);
    wr(`OFF_POWER_SIGNAL, 32'hFFFF_FFFF);
    rd(`OFF_POWER_SIGNAL, 32'hFFFF_FFFF, 32'h0000_01FF);
    chk_word({23'h0, power_signal_valid, power_signal_data}, 32'h0000_01FF);
    // Software cannot set the wake cause flags
    wr(`OFF_XCVR_CTRL, 32'hFFFF_FFFF);
    rd(`OFF_XCVR_CTRL, 32'hFFFF_FFFF, 32'h0004_0FF0);
    chk_word({29'h0, cfg_pins}, 32'h0000_0007);
    chk_bit(pd_a | pd_b, 1'b0);
    wr(`OFF_XCVR_CTRL, 32'h0000_0050);
    chk_word({29'h0, cfg_pins}, 32'h0000_0005);
    chk_bit(pd_a & pd_b, 1'b1);
    wr(32'h0000_005C, 32'hFFFF_FFFF);
    rd(32'h0000_005C, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(`OFF_OTG_FLAG_MASK, 32'hFFFF_FFFF, 32'hA5A5_5A5A);
    // Filter: a glitch one cycle short is dropped, a full hold passes
    for (int k = 1; k <= 3; k = k + 2) begin
      n = 1 << k;
      wr(`OFF_XCVR_CTRL, k << 8);
      u_usb_xcvr_model.put(LS_J);
      repeat (n + 4) @(posedge core_clk);
      u_usb_xcvr_model.put(LS_K);
      repeat (n - 2) @(posedge core_clk);
      u_usb_xcvr_model.put(LS_J);
      repeat (n + 4) @(posedge core_clk);
      rd(`OFF_LINE_STATUS, 32'h0000_0003, 32'h0000_0001);
      u_usb_xcvr_model.put(LS_K);
      repeat (n + 2) @(posedge core_clk);
      rd(`OFF_LINE_STATUS, 32'h0000_0003, 32'h0000_0002);
    end
    // Automatic resume by K, then by SE0 with the interrupt masked
    for (int i = 0; i < 2; i++) begin
      wv = (i == 0) ? LS_K : LS_SE0;
      wr(`OFF_IRQ_ENABLE, (i == 0) ? 32'h0000_0007 : 32'h0000_0000);
      wr(`OFF_XCVR_CTRL, 32'h0000_0080);
      u_usb_xcvr_model.put(LS_J);
      wr(`OFF_IRQ_CLEAR, 32'h0000_0007);
      u_usb_xcvr_model.set_susp(1'b1);
      repeat (4) @(posedge core_clk);
      rd(`OFF_LINE_STATUS, 32'h0000_0004, 32'h0000_0004);
      u_usb_xcvr_model.put(wv);
      cnt = 0;
      // Looked at mid-cycle, where the one-cycle pulse stands
      while (auto_wake !== 1'b1 && cnt < 20) begin
        @(negedge core_clk);
        cnt = cnt + 1;
      end
      chk_bit(auto_wake, 1'b1);
      repeat (2) @(posedge core_clk);
      chk_bit(irq, (i == 0));
      rd(`OFF_XCVR_CTRL, 32'hFFFF_FFFF, 32'h0000_0080 | (32'h0000_1000 << i));
      rd(`OFF_IRQ_STATUS, 32'h0000_0003, 32'h0000_0001 << i);
      wr(`OFF_IRQ_CLEAR, 32'h0000_0007);
      chk_bit(irq, 1'b0);
      wr(`OFF_XCVR_CTRL, 32'h0000_0080);
      rd(`OFF_XCVR_CTRL, 32'hFFFF_FFFF, 32'h0000_0080);
    end
    // Without the controller no wake happens; software polls the line
    wr(`OFF_XCVR_CTRL, 32'h0000_0000);
    u_usb_xcvr_model.put(LS_J);
    u_usb_xcvr_model.set_susp(1'b1);
    repeat (4) @(posedge core_clk);
    u_usb_xcvr_model.put(LS_K);
    cnt = 0;
    repeat (20) begin
      @(posedge core_clk);
      cnt = cnt + (auto_wake === 1'b1);
    end
    chk_word(cnt, 0);
    rd(`OFF_LINE_STATUS, 32'h0000_0007, 32'h0000_0002);
    rd(`OFF_XCVR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    finish_test();
  end
endmodule : usb_phy_control_registers_tb
